// ===== core/fws_pkg.sv
// shared constants, types and register map of the flash status-poll controller
package fws_pkg;

  // ************************************************************
  // clock and flash bus timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_ACC_NS      = 70;   // address/enable to data valid
  localparam int T_WC_NS       = 70;   // write cycle time
  localparam int T_WP_NS       = 35;   // write pulse width
  localparam int T_WPH_NS      = 20;   // write pulse width high
  localparam int T_OEH_NS      = 10;   // oe hold between toggle reads
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC  = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPH_CYC = ((T_WC_NS - T_WP_NS) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OEH_CYC = (T_OEH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W   = 4;

  // ************************************************************
  // flash data bit positions
  // ************************************************************
  localparam int POLLING_BIT  = 7;
  localparam int PRIMARY_BIT  = 6;
  localparam int TIMEOUT_BIT  = 5;
  localparam int WINDOW_BIT   = 3;
  localparam logic [7:0] RESET_CMD = 8'hF0;

  // ************************************************************
  // apb register map
  // ************************************************************
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] ADDR_OFS   = 8'h04;
  localparam logic [7:0] WDATA_OFS  = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_OP_LSB    = 1;
  localparam int CTRL_ABORT_BIT = 4;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_DONE_BIT    = 1;
  localparam int ST_FAIL_BIT    = 2;
  localparam int ST_POST_BIT    = 3;
  localparam int ST_PRE_BIT     = 4;
  localparam int ST_RDATA_LSB   = 8;
  localparam logic [18:0] ADDR_RESET  = 19'h00000;
  localparam logic [7:0]  WDATA_RESET = 8'h00;

  typedef enum logic [2:0] {
    OP_WRITE, OP_READ, OP_POLL, OP_RESET, OP_ADD_SECTOR
  } fws_op_t;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [18:0] addr;
    logic [7:0]  dq_out;
    logic        dq_oe;
  } fws_pins_t;

  typedef struct packed {
    logic        write;
    logic [18:0] addr;
    logic [7:0]  data;
  } fws_req_t;

endpackage

// ===== core/fws_bus_cycle.sv
// single flash read or write bus cycle engine
`timescale 1ns/100ps
module fws_bus_cycle (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              req_valid,
  input  fws_pkg::fws_req_t      req,
  input  wire logic [7:0]        dq_in,
  output fws_pkg::fws_pins_t     pins,
  output logic                   ack,
  output logic [7:0]             rdata
);
  import fws_pkg::*;

  typedef enum logic [1:0] {CY_IDLE, CY_ACTIVE, CY_RECOVER} fws_cyc_t;

  fws_cyc_t         st_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic             wr_reg;

  // ************************************************************
  // cycle sequencing
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg  <= CY_IDLE;
      cnt_reg <= '0;
      wr_reg  <= 1'b0;
      ack     <= 1'b0;
      rdata   <= 8'h00;
      pins    <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
    end else begin
      ack <= 1'b0;
      case (st_reg)
        CY_IDLE: begin
          if (req_valid) begin
            wr_reg      <= req.write;
            pins.addr   <= req.addr;
            pins.dq_out <= req.data;
            pins.dq_oe  <= req.write;
            pins.ce_n   <= 1'b0;
            pins.we_n   <= ~req.write;
            pins.oe_n   <= req.write;
            cnt_reg     <= CNT_W'(req.write ? WP_CYC : ACC_CYC);
            st_reg      <= CY_ACTIVE;
          end
        end
        CY_ACTIVE: begin
          if (cnt_reg > CNT_W'(1)) begin
            cnt_reg <= cnt_reg - CNT_W'(1);
          end else begin
            // data latches on the rising we edge, so dq stays driven one more cycle
            pins.we_n <= 1'b1;
            pins.oe_n <= 1'b1;
            pins.ce_n <= 1'b1;
            if (!wr_reg) begin
              rdata <= dq_in;
            end
            // every read ends with oe high, so each poll read is a full access
            cnt_reg <= CNT_W'(wr_reg ? WPH_CYC : OEH_CYC);
            st_reg  <= CY_RECOVER;
          end
        end
        CY_RECOVER: begin
          pins.dq_oe <= 1'b0;
          if (cnt_reg > CNT_W'(1)) begin
            cnt_reg <= cnt_reg - CNT_W'(1);
          end else begin
            ack    <= 1'b1;
            st_reg <= CY_IDLE;
          end
        end
        default: st_reg <= CY_IDLE;
      endcase
    end
  end

endmodule // fws_bus_cycle

// ===== core/fws_poll_ctrl.sv
// apb-controlled host that drives the flash and runs its toggle-poll procedure
// Summary of operation
// - host polls at valid address
// - host double-reads, compares toggle bit
// - toggling with bit 5 high: recheck, reset
// - interrupted polling restarts from double read
// - host writes reset after bit 5 failure
// - host may skip bit 3 under 50us spacing
// - host checks bit 3 around sector adds
// - single F0 write is reset command
`timescale 1ns/100ps
module fws_poll_ctrl (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [7:0]        dq_in,
  output fws_pkg::fws_pins_t     flash_pins
);
  import fws_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_SINGLE, ST_RD_A, ST_RD_B, ST_RD_C, ST_RD_D,
    ST_RESET_WR, ST_CHK_PRE, ST_CHK_CMD, ST_CHK_POST
  } fws_state_t;

  fws_state_t  state_reg;
  fws_op_t     op_reg;
  logic [18:0] addr_reg;
  logic [7:0]  wdata_reg;
  logic [7:0]  last_reg;
  logic [7:0]  first_reg;
  logic        busy_reg;
  logic        done_reg;
  logic        fail_reg;
  logic        pre_reg;
  logic        post_reg;
  logic        pend_reg;
  logic        req_valid_reg;
  logic        cyc_busy_reg;
  fws_req_t    req_reg;
  logic        cyc_ack;
  logic [7:0]  cyc_rdata;
  logic        wr_acc;
  logic        rd_acc;
  logic        mapped;
  logic        start_cmd;
  logic        abort_cmd;
  logic        need_write;
  logic [7:0]  need_data;
  logic        toggled;

  // ************************************************************
  // apb slave
  // ************************************************************
  assign mapped    = (paddr == CTRL_OFS) || (paddr == ADDR_OFS)
                   || (paddr == WDATA_OFS) || (paddr == STATUS_OFS);
  assign wr_acc    = psel && penable && pready && pwrite && mapped;
  assign rd_acc    = psel && !penable;
  assign start_cmd = wr_acc && (paddr == CTRL_OFS) && pwdata[CTRL_START_BIT] && !busy_reg;
  assign abort_cmd = wr_acc && (paddr == CTRL_OFS) && pwdata[CTRL_ABORT_BIT];

  // one wait-free answer: pready rises in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= rd_acc;
      pslverr <= rd_acc && !mapped;
      prdata  <= 32'h0000_0000;
      if (rd_acc && !pwrite) begin
        case (paddr)
          CTRL_OFS:   prdata <= 32'(op_reg) << CTRL_OP_LSB;
          ADDR_OFS:   prdata <= 32'(addr_reg);
          WDATA_OFS:  prdata <= 32'(wdata_reg);
          STATUS_OFS: prdata <= (32'(last_reg) << ST_RDATA_LSB)
                              | (32'(pre_reg) << ST_PRE_BIT)
                              | (32'(post_reg) << ST_POST_BIT)
                              | (32'(fail_reg) << ST_FAIL_BIT)
                              | (32'(done_reg) << ST_DONE_BIT)
                              | (32'(busy_reg) << ST_BUSY_BIT);
          default:    prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg  <= ADDR_RESET;
      wdata_reg <= WDATA_RESET;
      op_reg    <= OP_WRITE;
    end else if (wr_acc && !busy_reg) begin
      // poll address is software's: program target or erase-selected sector
      if (paddr == ADDR_OFS) addr_reg <= pwdata[18:0];
      if (paddr == WDATA_OFS) wdata_reg <= pwdata[7:0];
      if (paddr == CTRL_OFS) op_reg <= fws_op_t'(pwdata[CTRL_OP_LSB +: 3]);
    end
  end

  // ************************************************************
  // bus cycle issue
  // ************************************************************
  always_comb begin
    need_write = 1'b0;
    need_data  = wdata_reg;
    case (state_reg)
      ST_SINGLE:   need_write = (op_reg != OP_READ);
      ST_RESET_WR: begin
        need_write = 1'b1;
        need_data  = RESET_CMD;
      end
      ST_CHK_CMD:  need_write = 1'b1;
      default:     need_write = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_reg      <= 1'b0;
      req_valid_reg <= 1'b0;
      req_reg       <= '0;
    end else begin
      req_valid_reg <= 1'b0;
      if (state_reg == ST_IDLE || abort_cmd) begin
        pend_reg <= 1'b0;
      end else if (!pend_reg && !cyc_busy_reg) begin
        pend_reg      <= 1'b1;
        req_valid_reg <= 1'b1;
        req_reg       <= '{write: need_write, addr: addr_reg, data: need_data};
      end else if (cyc_ack) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // an aborted cycle still runs to its end, so a new request waits for its ack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_busy_reg <= 1'b0;
    end else if (req_valid_reg) begin
      cyc_busy_reg <= 1'b1;
    end else if (cyc_ack) begin
      cyc_busy_reg <= 1'b0;
    end
  end

  // ************************************************************
  // toggle poll sequencer
  // ************************************************************
  assign toggled = cyc_rdata[PRIMARY_BIT] != first_reg[PRIMARY_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
      fail_reg  <= 1'b0;
      pre_reg   <= 1'b0;
      post_reg  <= 1'b0;
      first_reg <= 8'h00;
      last_reg  <= 8'h00;
    end else if (abort_cmd) begin
      // leaving mid-poll: the next poll starts again with a fresh double read
      state_reg <= ST_IDLE;
      busy_reg  <= 1'b0;
    end else if (start_cmd) begin
      busy_reg <= 1'b1;
      done_reg <= 1'b0;
      fail_reg <= 1'b0;
      case (fws_op_t'(pwdata[CTRL_OP_LSB +: 3]))
        OP_POLL:       state_reg <= ST_RD_A;
        OP_RESET:      state_reg <= ST_RESET_WR;
        OP_ADD_SECTOR: state_reg <= ST_CHK_PRE;
        default:       state_reg <= ST_SINGLE;
      endcase
    end else if (pend_reg && cyc_ack) begin
      last_reg <= cyc_rdata;
      case (state_reg)
        ST_RD_A: begin
          first_reg <= cyc_rdata;
          state_reg <= ST_RD_B;
        end
        ST_RD_B: begin
          first_reg <= cyc_rdata;
          if (!toggled) begin
            state_reg <= ST_IDLE;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b1;
          end else if (cyc_rdata[TIMEOUT_BIT]) begin
            state_reg <= ST_RD_C;
          end else begin
            state_reg <= ST_RD_A;
          end
        end
        ST_RD_C: begin
          first_reg <= cyc_rdata;
          state_reg <= ST_RD_D;
        end
        ST_RD_D: begin
          if (toggled) begin
            // still toggling after bit 5 rose: failed, send the reset command
            fail_reg  <= 1'b1;
            state_reg <= ST_RESET_WR;
          end else begin
            state_reg <= ST_IDLE;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b1;
          end
        end
        ST_CHK_PRE: begin
          // window state before each added sector; skipping it is unsafe at slow pacing
          pre_reg   <= cyc_rdata[WINDOW_BIT];
          state_reg <= ST_CHK_CMD;
        end
        ST_CHK_CMD:  state_reg <= ST_CHK_POST;
        ST_CHK_POST: begin
          // high here means the added sector may not have been taken
          post_reg  <= cyc_rdata[WINDOW_BIT];
          state_reg <= ST_IDLE;
          busy_reg  <= 1'b0;
          done_reg  <= 1'b1;
        end
        default: begin
          state_reg <= ST_IDLE;
          busy_reg  <= 1'b0;
          done_reg  <= 1'b1;
        end
      endcase
    end
  end

  fws_bus_cycle u_cycle (
    .pclk      (pclk),
    .presetn   (presetn),
    .req_valid (req_valid_reg),
    .req       (req_reg),
    .dq_in     (dq_in),
    .pins      (flash_pins),
    .ack       (cyc_ack),
    .rdata     (cyc_rdata)
  );

endmodule // fws_poll_ctrl

// ===== sim/fws_poll_ctrl_chk.sv
// port assertions of the flash status-poll controller
`timescale 1ns/100ps
module fws_poll_ctrl_chk (
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input fws_pkg::fws_pins_t flash_pins
);
  import fws_pkg::*;
  // ****************
  // helpers
  // ****************
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic dq_oe;
  assign ce_n  = flash_pins.ce_n;
  assign oe_n  = flash_pins.oe_n;
  assign we_n  = flash_pins.we_n;
  assign dq_oe = flash_pins.dq_oe;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence rd_low;
    (!ce_n && !oe_n && we_n) [*3];
  endsequence
  sequence wr_low;
    (!ce_n && !we_n && dq_oe) [*2];
  endsequence
  // ****************
  // assertions
  // ****************
  a_setup_answered: assert property (psel && !penable |=> pready)
    else $error("setup not answered");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_read_strobe: assert property ($fell(oe_n) |-> rd_low ##1 (ce_n && oe_n))
    else $error("read strobe shape wrong");
  a_write_strobe: assert property ($fell(we_n) |-> wr_low ##1 (we_n && ce_n) ##1 (we_n && !dq_oe))
    else $error("write strobe shape wrong");
  a_addr_steady: assert property (!oe_n && !$past(oe_n) |-> $stable(flash_pins.addr))
    else $error("address moved in read");
  a_no_contention: assert property (!oe_n |-> !dq_oe)
    else $error("data driven during read");
  a_gap_after_cycle: assert property ($rose(ce_n) |-> oe_n && we_n)
    else $error("enables not released");
endmodule // fws_poll_ctrl_chk

// ===== sim/fws_flash_model.sv
// behavioural flash device answering status and array reads
`timescale 1ns/100ps
module fws_flash_model (
  input fws_pkg::fws_pins_t pins,
  output logic [7:0]         dq_in
);
  import fws_pkg::*;
  // ****************
  // state, 0 array, 1 running, 2 erase suspended in sector 2
  // ****************
  logic [1:0] mode = 2'h0;
  int         left = 0;
  int         rd_cnt = 0;
  logic       fail = 1'b0;
  logic       win = 1'b0;
  logic       win_nxt = 1'b0;
  logic       t6 = 1'b0;
  logic       t2 = 1'b0;
  logic       rdg = 1'b0;
  logic       wrg = 1'b0;
  logic [7:0] last = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic       stat;
  logic [7:0] rd_val;
  task automatic arm(input logic [1:0] m, input int n, input logic f, input logic w0,
                     input logic w1);
    mode    = m;
    left    = n;
    fail    = f;
    win     = w0;
    win_nxt = w1;
    rd_cnt  = 0;
  endtask
  assign stat   = (mode == 2'h1) || (mode == 2'h2 && pins.addr[18:16] == 3'h2);
  // array pattern is arbitrary, only needs to be steady
  assign rd_val = stat ? {mode == 2'h2, t6, fail, 1'b0, win, t2, 2'b00}
                       : pins.addr[7:0] ^ 8'hA5;
  // released bus shows the inverse, so a late sample cannot pass
  assign dq_in  = (!pins.ce_n && !pins.oe_n) ? rd_val : ~last;
  always @(pins.ce_n or pins.oe_n or pins.we_n) begin
    if (!pins.ce_n && !pins.oe_n) begin
      rdg = 1'b1;
    end else if (rdg) begin
      rdg = 1'b0;
      last = rd_val;
      rd_cnt++;
      if (stat) t2 = ~t2;
      if (mode == 2'h1) begin
        t6 = ~t6;
        if (!fail && left <= 1) mode = 2'h0;
        left--;
      end
    end
    if (!pins.ce_n && !pins.we_n) begin
      wrg = 1'b1;
    end else if (wrg) begin
      wrg = 1'b0;
      wr_data = pins.dq_out;
      if (pins.dq_out === RESET_CMD) begin
        mode = 2'h0;
        fail = 1'b0;
      end else begin
        win = win_nxt;
      end
    end
  end
endmodule // fws_flash_model

// ===== sim/fws_poll_ctrl_bench.sv
// self-checking bench of the flash status-poll controller
`timescale 1ns/100ps
module fws_poll_ctrl_bench;
  import fws_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  dq_in;
  fws_pins_t   flash_pins;
  logic [31:0] rd;
  logic        er;
  int          error_cnt = 0;
  int          num_checks = 0;
  fws_poll_ctrl u_fws_poll_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dq_in(dq_in), .flash_pins(flash_pins));
  fws_flash_model u_fws_flash_model (.pins(flash_pins), .dq_in(dq_in));
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  // ****************
  // access tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [2:0] op, input logic [18:0] a, input logic [7:0] d);
    apb(1'b1, ADDR_OFS, {13'h0, a});
    apb(1'b1, WDATA_OFS, {24'h0, d});
    apb(1'b1, CTRL_OFS, {28'h0, op, 1'b1});
    do apb(1'b0, STATUS_OFS, 32'h0); while (rd[ST_DONE_BIT] !== 1'b1);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ****************
  // tests
  // ****************
  initial begin
    #(25 * 20000);
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk({flash_pins.ce_n, flash_pins.oe_n, flash_pins.we_n, flash_pins.dq_oe}, 32'hE);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chk(er, 32'h1);
    u_fws_flash_model.arm(2'h1, 5, 1'b0, 1'b0, 1'b0);
    run(OP_POLL, 19'h00040, 8'h00);
    chk(rd[ST_FAIL_BIT], 32'h0);
    chk(u_fws_flash_model.rd_cnt >= 6, 32'h1);
    u_fws_flash_model.arm(2'h1, 5, 1'b1, 1'b0, 1'b0);
    run(OP_POLL, 19'h00040, 8'h00);
    chk(rd[ST_FAIL_BIT], 32'h1);
    chk(u_fws_flash_model.rd_cnt, 32'h4);
    chk(u_fws_flash_model.wr_data, 32'hF0);
    u_fws_flash_model.arm(2'h1, 1000, 1'b0, 1'b0, 1'b0);
    apb(1'b1, CTRL_OFS, {28'h0, OP_POLL, 1'b1});
    repeat (40) @(posedge pclk);
    apb(1'b1, CTRL_OFS, 32'h10);
    repeat (8) @(posedge pclk);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk(rd[ST_BUSY_BIT], 32'h0);
    u_fws_flash_model.arm(2'h0, 0, 1'b0, 1'b0, 1'b0);
    run(OP_POLL, 19'h00040, 8'h00);
    chk(u_fws_flash_model.rd_cnt, 32'h2);
    u_fws_flash_model.arm(2'h2, 0, 1'b0, 1'b0, 1'b0);
    run(OP_READ, 19'h00012, 8'h00);
    chk(rd[15:8], 32'hB7);
    u_fws_flash_model.arm(2'h2, 0, 1'b0, 1'b0, 1'b0);
    run(OP_POLL, 19'h20034, 8'h00);
    chk(u_fws_flash_model.rd_cnt, 32'h2);
    chk({rd[15], rd[13]}, 32'h2);
    u_fws_flash_model.arm(2'h1, 1000, 1'b0, 1'b0, 1'b1);
    run(OP_ADD_SECTOR, 19'h20000, 8'h30);
    chk(rd[ST_PRE_BIT], 32'h0);
    chk(rd[ST_POST_BIT], 32'h1);
    chk(u_fws_flash_model.wr_data, 32'h30);
    run(OP_RESET, 19'h00000, 8'h00);
    chk(u_fws_flash_model.mode, 32'h0);
    run(OP_WRITE, 19'h00077, 8'h5A);
    chk(u_fws_flash_model.wr_data, 32'h5A);
    close_out();
  end
endmodule // fws_poll_ctrl_bench

bind fws_poll_ctrl fws_poll_ctrl_chk u_fws_poll_ctrl_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .flash_pins(flash_pins));
